// *** logic/acpc_top.sv ***
// accumulator command pulse control with ahb-lite register slave
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module acpc_top import acpc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // timing chain and decoder
  input wire logic [6:0] timing_pulse,
  input wire logic execute_state,
  input wire logic [3:0] opcode_reg,
  input wire logic load_immediate_op,
  input wire logic operate_op,
  // arithmetic extension unit requests
  input wire logic ext_xor_req,
  input wire logic ext_carry_req,
  input wire logic complement_link_req,
  input wire logic ext_invert_req,
  input wire logic ext_rotate_right_req,
  input wire logic ext_rotate_left_req,
  // command pulses, one cycle after their cause
  output logic xor_transfer_cmd,
  output logic carry_propagate_cmd,
  output logic end_around_carry_cmd,
  output logic link_complement_cmd,
  output logic acc_invert_cmd,
  output logic rotate_right_cmd,
  output logic rotate_left_cmd,
  output logic and_clear_cmd,
  output logic operate_strobe_a,
  output logic operate_strobe_b,
  output logic rotate_strobe,
  output logic top_bit_carry_out,
  // register state
  output logic [17:0] accumulator,
  output logic link_flag
);

  // one-hot decode of a two-bit opcode half
  function automatic logic [3:0] acpc_dec4(input logic [1:0] v);
    acpc_dec4 = 4'h1 << v;
  endfunction : acpc_dec4

  // instruction bit k, bit 0 being the most significant of the word
  function automatic logic acpc_ibit(input logic [17:0] w, input int unsigned k);
    acpc_ibit = w[WORD_W - 1 - k];
  endfunction : acpc_ibit

  // state
  logic [17:0] acc_reg; // accumulator, [17] is word bit 0
  logic [17:0] acc_next;
  logic [17:0] membuf_reg; // memory buffer, written by software
  logic link_reg;
  logic link_next;
  logic [8:0] status_reg; // last cycle's command pulses
  // bus data-phase capture
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  // opcode group levels
  logic [3:0] upper_grp;
  logic [3:0] lower_grp;
  logic upper_group_1;
  logic upper_group_2;
  logic lower_group_2;
  logic lower_group_3;
  assign upper_grp = acpc_dec4(opcode_reg[3:2]); // RQ23
  assign lower_grp = acpc_dec4(opcode_reg[1:0]); // RQ23
  assign upper_group_1 = upper_grp[GRP_ONE];
  assign upper_group_2 = upper_grp[GRP_TWO];
  assign lower_group_2 = lower_grp[GRP_TWO];
  assign lower_group_3 = lower_grp[GRP_THREE];

  // execute-state instruction levels
  logic exec_grp1; // load, xor, ones add, twos add
  logic exec_ones_add;
  logic exec_twos_add;
  logic exec_skip; // skip-if-differ execute
  logic exec_and;
  assign exec_grp1 = execute_state & upper_group_1;
  assign exec_ones_add = exec_grp1 & lower_group_2;
  assign exec_twos_add = exec_grp1 & lower_group_3;
  assign exec_skip = execute_state & upper_group_2 & lower_group_3; // RQ7
  assign exec_and = execute_state & upper_group_2 & lower_group_2; // RQ21

  // pulse triggers for this cycle
  logic xor_go;
  logic carry_go;
  logic inv_go;
  logic andc_go;
  logic op_b_go;
  logic op_a_go;
  logic rot_go;
  logic rot_r_go; // rotate right this cycle
  logic rot_l_go; // rotate left this cycle
  logic lnk_req_go;
  assign xor_go = ext_xor_req // RQ3
    | (load_immediate_op & timing_pulse[TP_T6]) // RQ4
    | (exec_grp1 & timing_pulse[TP_T3]) // RQ5
    | (exec_skip & (timing_pulse[TP_T3] | timing_pulse[TP_T6])); // RQ6
  assign carry_go = ext_carry_req // RQ9
    | ((exec_ones_add | exec_twos_add) & timing_pulse[TP_T4]); // RQ8
  assign op_b_go = operate_op & timing_pulse[TP_T7]; // RQ16
  assign op_a_go = operate_op & timing_pulse[TP_T7];
  assign inv_go = ext_invert_req | (op_b_go & acpc_ibit(membuf_reg, IB_INVERT)); // RQ14 RQ15
  assign andc_go = exec_and & timing_pulse[TP_T5]; // RQ21
  // second rotate strobe only when the double bit is set
  assign rot_go = (operate_op & timing_pulse[TP_T5])
    | (op_a_go & acpc_ibit(membuf_reg, IB_DOUBLE)); // RQ17 RQ18
  // extension requests bypass the strobe so they act in any cycle
  assign rot_r_go = ext_rotate_right_req
    | (rot_go & acpc_ibit(membuf_reg, IB_RIGHT)); // RQ17 RQ19
  assign rot_l_go = ext_rotate_left_req
    | (rot_go & acpc_ibit(membuf_reg, IB_LEFT)); // RQ17 RQ19
  assign lnk_req_go = complement_link_req
    | (op_b_go & acpc_ibit(membuf_reg, IB_LINK)); // RQ11 RQ12

  // bus write in its data phase
  logic wr_acc;
  logic wr_mb;
  logic wr_link;
  assign wr_acc = wr_pend_reg & (wr_addr_reg == OFS_ACC);
  assign wr_mb = wr_pend_reg & (wr_addr_reg == OFS_MEMBUF);
  assign wr_link = wr_pend_reg & (wr_addr_reg == OFS_LINK);

  // datapath: pulses applied in timing chain order on top of a bus write
  logic [18:0] sum_w; // carry sum with top carry out
  logic [18:0] ring_w; // link and accumulator ring
  logic cout_w; // carry out of word bit 0
  logic end_go; // end-around carry issued
  logic twos_flip_go; // link complement from twos overflow
  always_comb begin
    acc_next = wr_acc ? hwdata[WORD_W-1:0] : acc_reg;
    link_next = wr_link ? hwdata[0] : link_reg;
    sum_w = 19'h00000;
    ring_w = 19'h00000;
    cout_w = 1'b0;
    end_go = 1'b0;
    twos_flip_go = 1'b0;
    // exclusive-or transfer first
    if (xor_go) begin
      acc_next = acc_next ^ membuf_reg; // RQ1
    end
    // carries where both words held a one, after the xor
    if (carry_go) begin
      sum_w = {1'b0, acc_next} + {(membuf_reg & ~acc_next), 1'b0}; // RQ1
      cout_w = sum_w[WORD_W];
      acc_next = sum_w[WORD_W-1:0];
    end
    // end-around carry only for ones add; twos add never feeds bit 17
    if (cout_w && exec_ones_add) begin
      end_go = 1'b1; // RQ10
      acc_next = acc_next + 18'h00001; // RQ1 RQ10
    end
    if (cout_w && exec_twos_add) begin
      twos_flip_go = 1'b1; // RQ2 RQ13
    end
    // and-clear keeps bits where the buffer holds a one
    if (andc_go) begin
      acc_next = acc_next & membuf_reg; // RQ20
    end
    if (inv_go) begin
      acc_next = ~acc_next; // RQ15
    end
    // a link request (extension or operate bit 16) and a twos overflow in one cycle cancel
    if (lnk_req_go ^ twos_flip_go) begin
      link_next = ~link_next; // RQ2 RQ12 RQ13
    end
    // rotates last, right before left when both are asked
    ring_w = {link_next, acc_next};
    if (rot_r_go) begin
      ring_w = {ring_w[0], ring_w[18:1]}; // RQ24
    end
    if (rot_l_go) begin
      ring_w = {ring_w[17:0], ring_w[18]}; // RQ24
    end
    acc_next = ring_w[17:0]; // RQ22 RQ25
    link_next = ring_w[18];
  end

  // accumulator and link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= ACC_RST;
      link_reg <= LINK_RST;
    end else begin
      acc_reg <= acc_next;
      link_reg <= link_next;
    end
  end

  // memory buffer, software only; no command pulse ever alters it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      membuf_reg <= MEMBUF_RST;
    end else if (wr_mb) begin
      membuf_reg <= hwdata[WORD_W-1:0];
    end
  end

  // command pulse outputs, registered for clean edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xor_transfer_cmd <= 1'b0;
      carry_propagate_cmd <= 1'b0;
      end_around_carry_cmd <= 1'b0;
      link_complement_cmd <= 1'b0;
      acc_invert_cmd <= 1'b0;
      rotate_right_cmd <= 1'b0;
      rotate_left_cmd <= 1'b0;
      and_clear_cmd <= 1'b0;
      operate_strobe_a <= 1'b0;
      operate_strobe_b <= 1'b0;
      rotate_strobe <= 1'b0;
      top_bit_carry_out <= 1'b0;
    end else begin
      xor_transfer_cmd <= xor_go;
      carry_propagate_cmd <= carry_go;
      end_around_carry_cmd <= end_go;
      link_complement_cmd <= lnk_req_go | twos_flip_go;
      acc_invert_cmd <= inv_go;
      rotate_right_cmd <= rot_r_go;
      rotate_left_cmd <= rot_l_go;
      and_clear_cmd <= andc_go;
      operate_strobe_a <= op_a_go;
      operate_strobe_b <= op_b_go;
      rotate_strobe <= rot_go;
      top_bit_carry_out <= cout_w;
    end
  end

  // status snapshot of the last cycle's pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= 9'h000;
    end else begin
      status_reg[ST_XOR] <= xor_go;
      status_reg[ST_CARRY] <= carry_go;
      status_reg[ST_END] <= end_go;
      status_reg[ST_LINKC] <= lnk_req_go | twos_flip_go;
      status_reg[ST_INV] <= inv_go;
      status_reg[ST_ROT_R] <= rot_r_go;
      status_reg[ST_ROT_L] <= rot_l_go;
      status_reg[ST_ANDC] <= andc_go;
      status_reg[ST_COUT] <= cout_w;
    end
  end

  // register outputs mirror state
  assign accumulator = acc_reg;
  assign link_flag = link_reg;

  // ahb address phase; zero wait, so every NONSEQ request is taken
  logic addr_ok;
  assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // read data captured at the address phase, unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      if (haddr[7:0] == OFS_ACC) begin
        hrdata <= {14'h0000, acc_next};
      end else if (haddr[7:0] == OFS_MEMBUF) begin
        hrdata <= {14'h0000, membuf_reg};
      end else if (haddr[7:0] == OFS_LINK) begin
        hrdata <= {31'h00000000, link_next};
      end else if (haddr[7:0] == OFS_STATUS) begin
        hrdata <= {23'h000000, status_reg};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // always ready, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ld_imm_xor: assert property (load_immediate_op && timing_pulse[TP_T6] |=> xor_transfer_cmd) // RQ4
    else $error("xor missing for load immediate");
  a_grp1_xor: assert property (exec_grp1 && timing_pulse[TP_T3] |=> xor_transfer_cmd) // RQ5
    else $error("xor missing at T3");
  a_ext_xor_cmd: assert property (ext_xor_req |=> xor_transfer_cmd) // RQ3
    else $error("xor missing for extension request");
  a_skip_second_xor: assert property (exec_skip && timing_pulse[TP_T6] |=> xor_transfer_cmd) // RQ6
    else $error("second xor missing for skip");
  a_add_carry_t4: assert property ((exec_ones_add || exec_twos_add) && timing_pulse[TP_T4]
    |=> carry_propagate_cmd) // RQ8
    else $error("carry missing at T4");
  a_ext_carry_cmd: assert property (ext_carry_req |=> carry_propagate_cmd) // RQ9
    else $error("carry missing for extension request");
  a_end_only_ones: assert property (end_around_carry_cmd |-> $past(exec_ones_add)
    && top_bit_carry_out) // RQ10
    else $error("end carry outside ones add");
  a_twos_no_feed: assert property (exec_twos_add && carry_go && !xor_go && !inv_go && !andc_go
    && !rot_r_go && !rot_l_go && !wr_acc |=> accumulator == $past(sum_w[17:0])) // RQ2
    else $error("twos add altered low bit");
  a_op_strobe_b: assert property (operate_strobe_b == $past(operate_op && timing_pulse[TP_T7])) // RQ16
    else $error("operate strobe wrong");
  a_req_link_flip: assert property (complement_link_req && !twos_flip_go && !rot_r_go && !rot_l_go
    && !wr_link |=> link_flag != $past(link_flag)) // RQ11
    else $error("link not complemented");
  a_invert_operate: assert property (operate_op && timing_pulse[TP_T7] && membuf_reg[0]
    |=> acc_invert_cmd) // RQ15
    else $error("invert missing at T7");
  // extension invert request acts in any cycle
  a_ext_invert_cmd: assert property (ext_invert_req |=> acc_invert_cmd) // RQ14
    else $error("invert missing for extension request");
  // operate bit 16 always reports a link complement pulse
  a_op_link_flip: assert property (operate_op && timing_pulse[TP_T7] && membuf_reg[1]
    |=> link_complement_cmd) // RQ12
    else $error("link complement missing at T7");
  // single rotate at T5 follows the right bit
  a_rotate_right_t5: assert property (operate_op && timing_pulse[TP_T5] && membuf_reg[4]
    |=> rotate_right_cmd) // RQ17
    else $error("rotate right missing at T5");
  // extension rotate left request acts in any cycle
  a_ext_rotate_left: assert property (ext_rotate_left_req |=> rotate_left_cmd) // RQ19
    else $error("rotate left missing for extension request");
  a_and_clear_t5: assert property (exec_and && timing_pulse[TP_T5] |=> and_clear_cmd) // RQ21
    else $error("and clear missing at T5");
  a_and_clear_mask: assert property (and_clear_cmd && !$past(inv_go) && !$past(rot_r_go)
    && !$past(rot_l_go) |-> (accumulator & ~membuf_reg) == 18'h00000 || $past(wr_mb)) // RQ20
    else $error("and clear left bits set");
  a_double_rotate: assert property (operate_op && timing_pulse[TP_T7] && membuf_reg[10]
    && membuf_reg[4] |=> rotate_right_cmd) // RQ18
    else $error("second rotate missing");

  // main scenarios worth seeing at least once
  c_skip_twice: cover property (exec_skip && timing_pulse[TP_T3] ##[1:8] exec_skip
    && timing_pulse[TP_T6]);
  c_end_around: cover property (end_around_carry_cmd);
  c_twos_link: cover property (exec_twos_add && cout_w);
  c_two_place: cover property (rotate_strobe && operate_strobe_a);

endmodule : acpc_top

// *** shared/acpc_pkg.sv ***
// constants for the accumulator command pulse control block
// Functional notes
// RQ1 - xor, carry, end-around carry gives ones add
// RQ2 - twos add sends top overflow to link
// RQ3 - extension xor request issues xor transfer
// RQ4 - load immediate issues xor at T6
// RQ5 - load/xor/add group issues xor at T3
// RQ6 - skip-if-differ issues xor at T3, T6
// RQ7 - skip-if-differ is execute, groups two, three
// RQ8 - either add issues carry propagate at T4
// RQ9 - extension carry request issues carry propagate
// RQ10 - ones add top-bit overflow gives end carry
// RQ11 - extension link request complements link
// RQ12 - operate bit 16 complements link at T7
// RQ13 - twos add top carry complements link
// RQ14 - extension invert request inverts accumulator
// RQ15 - operate bit 17 inverts accumulator at T7
// RQ16 - operate strobe is operate level and T7
// RQ17 - T5 rotate right bit 13, left 14
// RQ18 - bit 7 repeats rotate at T7
// RQ19 - extension rotate requests issue rotate pulses
// RQ20 - and-clear zeroes accumulator where buffer zero
// RQ21 - logical and, groups two, two, at T5
// RQ22 - 18-bit words, bit 0 most significant
// RQ23 - opcode halves decode to two one-hot groups
// RQ24 - rotate shifts 19-bit link-accumulator ring
// RQ25 - same-pulse commands apply in chain order
package acpc_pkg;
  // word geometry
  localparam int unsigned WORD_W = 18;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_MEMBUF = 8'h04;
  localparam logic [7:0] OFS_LINK = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  // reset values
  localparam logic [17:0] ACC_RST = 18'h00000;
  localparam logic [17:0] MEMBUF_RST = 18'h00000;
  localparam logic LINK_RST = 1'b0;
  // timing pulse positions in the one-hot timing vector (T1..T7)
  localparam int unsigned TP_T3 = 2;
  localparam int unsigned TP_T4 = 3;
  localparam int unsigned TP_T5 = 4;
  localparam int unsigned TP_T6 = 5;
  localparam int unsigned TP_T7 = 6;
  // instruction bit numbers, bit 0 most significant
  localparam int unsigned IB_DOUBLE = 7;
  localparam int unsigned IB_RIGHT = 13;
  localparam int unsigned IB_LEFT = 14;
  localparam int unsigned IB_LINK = 16;
  localparam int unsigned IB_INVERT = 17;
  // opcode group numbers
  localparam int unsigned GRP_ONE = 1;
  localparam int unsigned GRP_TWO = 2;
  localparam int unsigned GRP_THREE = 3;
  // status register bit positions
  localparam int unsigned ST_XOR = 0;
  localparam int unsigned ST_CARRY = 1;
  localparam int unsigned ST_END = 2;
  localparam int unsigned ST_LINKC = 3;
  localparam int unsigned ST_INV = 4;
  localparam int unsigned ST_ROT_R = 5;
  localparam int unsigned ST_ROT_L = 6;
  localparam int unsigned ST_ANDC = 7;
  localparam int unsigned ST_COUT = 8;
  // ahb constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : acpc_pkg

// *** sim/acpc_timing_model.sv ***
// behavioural timing chain: one run of pulses t1..t7 per start request
`timescale 1ns/1ps
module acpc_timing_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // cycle request
  input wire logic start,
  // timing pulses and activity
  output logic [6:0] timing_pulse,
  output logic busy
);
  logic [3:0] step_reg; // 0 idle, 1..7 stand for t1..t7

  // step through the chain once, then fall quiet so no stray pulse repeats
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_reg <= 4'h0;
    end else if (step_reg != 4'h0) begin
      step_reg <= (step_reg == 4'h7) ? 4'h0 : step_reg + 4'h1; // wrap ends the cycle
    end else if (start) begin
      step_reg <= 4'h1; // new cycle begins with t1
    end
  end

  // one-hot pulse vector, all low between cycles
  always_comb begin
    timing_pulse = (step_reg == 4'h0) ? 7'h00 : 7'(7'h01 << (step_reg - 4'h1));
  end

  assign busy = (step_reg != 4'h0); // chain running
endmodule : acpc_timing_model

// *** sim/tb.sv ***
// self-checking bench for the accumulator command pulse control
`timescale 1ns/1ps
module tb import acpc_pkg::*;;
  // clock, reset and bus
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  // decoder levels, extension requests, chain control
  logic execute_state, load_immediate_op, operate_op, start;
  logic [3:0] opcode_reg;
  logic [5:0] ext_req; // xor, carry, link, invert, right, left
  logic [6:0] timing_pulse;
  // observed outputs
  logic [11:0] cmds;
  logic [17:0] accumulator;
  logic link_flag;
  int cnt [12];
  int base [12];
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;

  always #2.5 hclk = ~hclk;
  assign hready = hreadyout; // single slave drives the bus ready

  acpc_timing_model tmodel_u (.hclk(hclk), .hresetn(hresetn), .start(start),
    .timing_pulse(timing_pulse), .busy());

  acpc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .timing_pulse(timing_pulse),
    .execute_state(execute_state), .opcode_reg(opcode_reg),
    .load_immediate_op(load_immediate_op), .operate_op(operate_op),
    .ext_xor_req(ext_req[0]), .ext_carry_req(ext_req[1]), .complement_link_req(ext_req[2]),
    .ext_invert_req(ext_req[3]), .ext_rotate_right_req(ext_req[4]),
    .ext_rotate_left_req(ext_req[5]), .xor_transfer_cmd(cmds[0]),
    .carry_propagate_cmd(cmds[1]), .end_around_carry_cmd(cmds[2]),
    .link_complement_cmd(cmds[3]), .acc_invert_cmd(cmds[4]), .rotate_right_cmd(cmds[5]),
    .rotate_left_cmd(cmds[6]), .and_clear_cmd(cmds[7]), .operate_strobe_a(cmds[8]),
    .operate_strobe_b(cmds[9]), .rotate_strobe(cmds[10]), .top_bit_carry_out(cmds[11]),
    .accumulator(accumulator), .link_flag(link_flag));

  // count pulses on the falling edge, well clear of the launching edge
  always @(negedge hclk) begin
    for (int i = 0; i < 12; i++) begin
      cnt[i] += int'(cmds[i] === 1'b1);
    end
  end

  // hang guard, far above the roughly 300 cycles the tests need
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  // pulses seen since the last snapshot, two bits per command
  function automatic logic [23:0] seen_cnt();
    logic [23:0] v;
    v = 24'h000000;
    for (int i = 0; i < 12; i++) begin
      v[2*i +: 2] = 2'(cnt[i] - base[i]);
    end
    return v;
  endfunction : seen_cnt

  // expected count n for command i
  function automatic logic [23:0] ec(input int i, input int n);
    return 24'(n) << (2 * i);
  endfunction : ec

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ahb-lite single write; entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : wr

  // ahb-lite single read; data taken at the edge ending the data phase
  task automatic rd(input logic [7:0] a, output logic [31:0] rdv);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= 1'b0;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    do @(posedge hclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask : rd

  // load state, run one processor cycle (or one extension pulse), check results
  task automatic op_test(input string nm, input logic [17:0] a, input logic [17:0] m,
      input logic lk, input logic [3:0] opc, input logic [2:0] ctl, input logic [5:0] rq,
      input logic [17:0] ea, input logic el, input logic [23:0] ecnt);
    wr(OFS_ACC, {14'h0000, a});
    wr(OFS_MEMBUF, {14'h0000, m});
    wr(OFS_LINK, {31'h00000000, lk});
    base = cnt;
    execute_state <= ctl[2];
    load_immediate_op <= ctl[1];
    operate_op <= ctl[0];
    opcode_reg <= opc;
    start <= (rq == 6'h00); // chain only when no extension request
    ext_req <= rq;
    @(posedge hclk);
    start <= 1'b0;
    ext_req <= 6'h00;
    repeat (10) @(posedge hclk); // seven pulses, one cycle of latency and two spare cycles
    execute_state <= 1'b0;
    load_immediate_op <= 1'b0;
    operate_op <= 1'b0;
    chk({nm, " acc"}, {14'h0000, ea}, {14'h0000, accumulator});
    chk({nm, " link"}, {31'h00000000, el}, {31'h00000000, link_flag});
    chk({nm, " pulses"}, {8'h00, ecnt}, {8'h00, seen_cnt()});
    $display("test %s done", nm);
  endtask : op_test

  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    start = 1'b0;
    ext_req = 6'h00;
    execute_state = 1'b0;
    opcode_reg = 4'h0;
    load_immediate_op = 1'b0;
    operate_op = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("hresp", 32'h0, {31'h0, hresp});
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), d); // last offset is unmapped
      chk("reset read", 32'h00000000, d);
    end
    wr(OFS_ACC, 32'hFFFFFFFF);
    rd(OFS_ACC, d);
    chk("acc width", 32'h0003FFFF, d);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, d);
    chk("unmapped", 32'h00000000, d);
    $display("test bus done");
    op_test("ones add", 18'h3FFFE, 18'h00003, 1'b0, 4'h6, 3'b100, 6'h00, 18'h00002, 1'b0,
      ec(0, 1) | ec(1, 1) | ec(2, 1) | ec(11, 1));
    op_test("twos add", 18'h3FFFF, 18'h00001, 1'b0, 4'h7, 3'b100, 6'h00, 18'h00000, 1'b1,
      ec(0, 1) | ec(1, 1) | ec(3, 1) | ec(11, 1));
    op_test("xor family", 18'h12345, 18'h2AAAA, 1'b0, 4'h5, 3'b100, 6'h00, 18'h389EF, 1'b0,
      ec(0, 1));
    op_test("skip differ", 18'h12345, 18'h2AAAA, 1'b0, 4'hB, 3'b100, 6'h00, 18'h12345, 1'b0,
      ec(0, 2));
    op_test("and", 18'h12345, 18'h2AAAA, 1'b0, 4'hA, 3'b100, 6'h00, 18'h02200, 1'b0,
      ec(7, 1));
    op_test("and idle", 18'h12345, 18'h2AAAA, 1'b0, 4'hA, 3'b000, 6'h00, 18'h12345, 1'b0,
      24'h0);
    op_test("load imm", 18'h12345, 18'h2AAAA, 1'b0, 4'hC, 3'b010, 6'h00, 18'h389EF, 1'b0,
      ec(0, 1));
    op_test("invert link", 18'h12345, 18'h00003, 1'b0, 4'hF, 3'b001, 6'h00, 18'h2DCBA, 1'b1,
      ec(3, 1) | ec(4, 1) | ec(8, 1) | ec(9, 1) | ec(10, 1));
    op_test("rotate r2", 18'h00001, 18'h00410, 1'b0, 4'hF, 3'b001, 6'h00, 18'h20000, 1'b0,
      ec(5, 2) | ec(8, 1) | ec(9, 1) | ec(10, 2));
    op_test("rotate l1", 18'h20000, 18'h00008, 1'b0, 4'hF, 3'b001, 6'h00, 18'h00000, 1'b1,
      ec(6, 1) | ec(8, 1) | ec(9, 1) | ec(10, 1));
    op_test("ext xor", 18'h00F0F, 18'h0, 1'b0, 4'h0, 3'b000, 6'h01, 18'h00F0F, 1'b0,
      ec(0, 1));
    op_test("ext carry", 18'h00F0F, 18'h0, 1'b0, 4'h0, 3'b000, 6'h02, 18'h00F0F, 1'b0,
      ec(1, 1));
    op_test("ext link", 18'h00F0F, 18'h0, 1'b0, 4'h0, 3'b000, 6'h04, 18'h00F0F, 1'b1,
      ec(3, 1));
    op_test("ext invert", 18'h00F0F, 18'h0, 1'b0, 4'h0, 3'b000, 6'h08, 18'h3F0F0, 1'b0,
      ec(4, 1));
    op_test("ext right", 18'h00F0F, 18'h0, 1'b0, 4'h0, 3'b000, 6'h10, 18'h00787, 1'b1,
      ec(5, 1));
    op_test("ext left", 18'h00F0F, 18'h0, 1'b0, 4'h0, 3'b000, 6'h20, 18'h01E1E, 1'b0,
      ec(6, 1));
    conclude();
  end
endmodule : tb
